// *** hw/line_port.sv ***
// Line pins: edge selection, rail format, local loopback, clock-loss watch
`timescale 1ns/10ps
module line_port
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Configuration
  line_cfg_if.line  cfg,
  // Framer core side
  input  wire logic tx_core_pos,
  input  wire logic tx_core_neg,
  output logic      rx_core_pos,
  output logic      rx_core_neg,
  // Line pins
  input  wire logic tx_line_clock,
  input  wire logic rx_line_clock,
  output logic      tx_line_pos_out,
  output logic      tx_line_neg_out,
  input  wire logic rx_line_pos_in,
  input  wire logic rx_line_neg_in
);
  logic                        txc_ff, rxc_ff, tx_edge, rx_edge;
  logic                        src_pos, src_neg;
  logic                        nxt_tpos, nxt_tneg, nxt_rpos, nxt_rneg;
  logic                        nxt_loc;
  logic [uni_ctrl_pkg::LOC_CW-1:0] txcnt_ff, rxcnt_ff, nxt_txcnt, nxt_rxcnt;

  // ------------------------------------------------------------------
  // Edge choice and data path
  // ------------------------------------------------------------------
  always_comb
  begin
    // Inverted mode reacts to the falling edge
    tx_edge = cfg.tx_inv ? (txc_ff & ~tx_line_clock)
                         : (~txc_ff & tx_line_clock);
    rx_edge = cfg.rx_inv ? (rxc_ff & ~rx_line_clock)
                         : (~rxc_ff & rx_line_clock);
    src_pos = cfg.local_lb ? tx_line_pos_out : rx_line_pos_in;
    src_neg = cfg.local_lb ? tx_line_neg_out : rx_line_neg_in;
    nxt_tpos = tx_edge ? tx_core_pos : tx_line_pos_out;
    // Single rail leaves the negative rail idle
    nxt_tneg = tx_edge ? (tx_core_neg & ~cfg.single_rail)
                       : tx_line_neg_out;
    nxt_rpos = rx_edge ? src_pos : rx_core_pos;
    nxt_rneg = rx_edge ? (src_neg & ~cfg.single_rail)
                       : rx_core_neg;
    nxt_txcnt = txcnt_ff;
    nxt_rxcnt = rxcnt_ff;
    if (txc_ff != tx_line_clock)
      nxt_txcnt = '0;
    else if (txcnt_ff != uni_ctrl_pkg::LOC_CW'(uni_ctrl_pkg::LOC_CYCLES))
      nxt_txcnt = txcnt_ff + 1'b1;
    if (rxc_ff != rx_line_clock)
      nxt_rxcnt = '0;
    else if (rxcnt_ff != uni_ctrl_pkg::LOC_CW'(uni_ctrl_pkg::LOC_CYCLES))
      nxt_rxcnt = rxcnt_ff + 1'b1;
    nxt_loc = ~cfg.loc_dis &
      ((txcnt_ff == uni_ctrl_pkg::LOC_CW'(uni_ctrl_pkg::LOC_CYCLES)) |
       (rxcnt_ff == uni_ctrl_pkg::LOC_CW'(uni_ctrl_pkg::LOC_CYCLES)));
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txc_ff          <= 1'b0;
      rxc_ff          <= 1'b0;
      tx_line_pos_out <= 1'b0;
      tx_line_neg_out <= 1'b0;
      rx_core_pos     <= 1'b0;
      rx_core_neg     <= 1'b0;
      txcnt_ff        <= '0;
      rxcnt_ff        <= '0;
      cfg.loc_flag    <= 1'b0;
    end
    else
    begin
      txc_ff          <= tx_line_clock;
      rxc_ff          <= rx_line_clock;
      tx_line_pos_out <= nxt_tpos;
      tx_line_neg_out <= nxt_tneg;
      rx_core_pos     <= nxt_rpos;
      rx_core_neg     <= nxt_rneg;
      txcnt_ff        <= nxt_txcnt;
      rxcnt_ff        <= nxt_rxcnt;
      cfg.loc_flag    <= nxt_loc;
    end
  end
endmodule

// *** hw/uni_ctrl_regs.sv ***
// Global control and status register bank of one framer channel
`timescale 1ns/10ps
module uni_ctrl_regs
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Parallel register port
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] host_wdata,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  output logic      [7:0] host_rdata,
  output logic            host_irq,
  // Block interrupt requests, bits 7..1, and one-second tick
  input  wire logic [7:1] block_irq_req,
  input  wire logic       one_second_tick,
  // Framer core line data
  input  wire logic       tx_core_pos,
  input  wire logic       tx_core_neg,
  output logic            rx_core_pos,
  output logic            rx_core_neg,
  // Line pins
  input  wire logic       tx_line_clock,
  input  wire logic       rx_line_clock,
  output logic            tx_line_pos_out,
  output logic            tx_line_neg_out,
  input  wire logic       rx_line_pos_in,
  input  wire logic       rx_line_neg_in,
  // Controls to sub-blocks
  output logic            framer_soft_reset,
  output logic            frame_search_restart,
  output logic            cell_loopback_en,
  output logic            plcp_loopback_en,
  output logic            plcp_enable,
  output logic            m13_select,
  output logic            b3zs_enable,
  output logic            clear_channel_mode,
  output logic            tx_overhead_serial_en,
  // Transmit timing source
  output logic            tx_loop_timing,
  output logic            use_eight_khz_ref,
  output logic            use_stuff_control,
  output logic            use_fixed_stuffing,
  output logic            use_tx_frame_ref,
  output logic            use_tx_input_clock
);
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  logic [7:0] opmode_ff, ioctl_ff, irqen_ff, tcctl_ff;
  logic [7:0] nxt_opmode, nxt_ioctl, nxt_irqen, nxt_tcctl;
  logic       sec_ff, nxt_sec;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       srst_ff, nxt_srst, refr_ff, nxt_refr;
  logic [7:0] irq_status, irq_mode_msk;
  logic       atm_mode, plcp_mode, wr_op, wr_io, rd_st;
  uni_ctrl_pkg::tref_t tref;

  line_cfg_if cfg ();

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  // Async assert, synchronous release through two stages
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  always_comb
  begin
    atm_mode  = ~tcctl_ff[uni_ctrl_pkg::TC_CLEAR_CH];
    plcp_mode = atm_mode & ~opmode_ff[uni_ctrl_pkg::OM_DIRECT];
    tref      = uni_ctrl_pkg::tref_t'(opmode_ff[1:0]);
    wr_op     = host_wr & (host_addr == uni_ctrl_pkg::OFS_OPMODE);
    wr_io     = host_wr & (host_addr == uni_ctrl_pkg::OFS_IOCTL);
    rd_st     = host_rd & (host_addr == uni_ctrl_pkg::OFS_IRQST);
    // Cell and UTOPIA bits only exist in ATM UNI, PLCP only in PLCP mode
    irq_mode_msk = {1'b1, plcp_mode,
                    atm_mode ? uni_ctrl_pkg::IRQ_ATM_MSK[5:2] : 4'h0,
                    2'h3};
    irq_status = {block_irq_req, sec_ff} & irq_mode_msk;
  end

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_opmode = opmode_ff;
    nxt_ioctl  = ioctl_ff;
    nxt_irqen  = irqen_ff;
    nxt_tcctl  = tcctl_ff;
    nxt_sec    = sec_ff;
    if (wr_op)
      nxt_opmode = host_wdata;
    if (wr_io)
      nxt_ioctl = host_wdata & uni_ctrl_pkg::IOCTL_WMSK;
    if (host_wr && host_addr == uni_ctrl_pkg::OFS_IRQEN)
      nxt_irqen = host_wdata;
    if (host_wr && host_addr == uni_ctrl_pkg::OFS_TCCTL)
      nxt_tcctl = host_wdata & uni_ctrl_pkg::TCCTL_WMSK;
    // Reading active status drops the matching enables
    if (rd_st && ioctl_ff[uni_ctrl_pkg::IO_EN_CLR])
      nxt_irqen = irqen_ff & ~irq_status;
    // A tick in the read cycle survives: set wins over clear
    if (rd_st)
      nxt_sec = 1'b0;
    if (one_second_tick)
      nxt_sec = 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opmode_ff <= uni_ctrl_pkg::OPMODE_RST;
      ioctl_ff  <= uni_ctrl_pkg::IOCTL_RST;
      irqen_ff  <= uni_ctrl_pkg::IRQEN_RST;
      tcctl_ff  <= uni_ctrl_pkg::TCCTL_RST;
      sec_ff    <= 1'b0;
    end
    else if (srst_ff)
    begin
      // Soft reset returns the bank to defaults as well
      opmode_ff <= uni_ctrl_pkg::OPMODE_RST;
      ioctl_ff  <= uni_ctrl_pkg::IOCTL_RST;
      irqen_ff  <= uni_ctrl_pkg::IRQEN_RST;
      tcctl_ff  <= uni_ctrl_pkg::TCCTL_RST;
      sec_ff    <= 1'b0;
    end
    else
    begin
      opmode_ff <= nxt_opmode;
      ioctl_ff  <= nxt_ioctl;
      irqen_ff  <= nxt_irqen;
      tcctl_ff  <= nxt_tcctl;
      sec_ff    <= nxt_sec;
    end
  end

  // ------------------------------------------------------------------
  // Write-edge pulses and read data
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_srst = wr_op & host_wdata[uni_ctrl_pkg::OM_RESET] &
               ~opmode_ff[uni_ctrl_pkg::OM_RESET];
    nxt_refr = wr_io & host_wdata[uni_ctrl_pkg::IO_FRAME_SEARCH_RESTART] &
               ~ioctl_ff[uni_ctrl_pkg::IO_FRAME_SEARCH_RESTART];
    nxt_rdata = rdata_ff;
    if (host_rd)
    begin
      case (host_addr)
        uni_ctrl_pkg::OFS_OPMODE: nxt_rdata = opmode_ff;
        uni_ctrl_pkg::OFS_IOCTL:
          nxt_rdata = {ioctl_ff[7], cfg.loc_flag, ioctl_ff[5:0]};
        uni_ctrl_pkg::OFS_PARTID: nxt_rdata = uni_ctrl_pkg::PART_ID_VAL;
        uni_ctrl_pkg::OFS_REVID:  nxt_rdata = uni_ctrl_pkg::REV_ID_VAL;
        uni_ctrl_pkg::OFS_IRQEN:  nxt_rdata = irqen_ff;
        uni_ctrl_pkg::OFS_IRQST:  nxt_rdata = irq_status;
        uni_ctrl_pkg::OFS_TCCTL:  nxt_rdata = tcctl_ff;
        default:                  nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_ff <= 8'h00;
      srst_ff  <= 1'b0;
      refr_ff  <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      srst_ff  <= nxt_srst;
      refr_ff  <= nxt_refr;
    end
  end

  // ------------------------------------------------------------------
  // Control outputs
  // ------------------------------------------------------------------
  always_comb
  begin
    host_rdata            = rdata_ff;
    host_irq              = |(irqen_ff & irq_status);
    framer_soft_reset     = srst_ff;
    frame_search_restart  = refr_ff;
    cell_loopback_en      = opmode_ff[uni_ctrl_pkg::OM_CELL_LB] &
                            atm_mode;
    plcp_loopback_en      = opmode_ff[uni_ctrl_pkg::OM_PLCP_LB] &
                            plcp_mode;
    plcp_enable           = plcp_mode;
    m13_select            = opmode_ff[uni_ctrl_pkg::OM_M13];
    // Dual-rail choice with B3ZS is left to software
    b3zs_enable           = ~ioctl_ff[uni_ctrl_pkg::IO_AMI];
    clear_channel_mode    = ~atm_mode;
    tx_overhead_serial_en = tcctl_ff[uni_ctrl_pkg::TC_OH_IN] &
                            atm_mode;
    tx_loop_timing        = 1'b0;
    use_eight_khz_ref     = 1'b0;
    use_stuff_control     = 1'b0;
    use_fixed_stuffing    = 1'b0;
    use_tx_frame_ref      = 1'b0;
    use_tx_input_clock    = 1'b0;
    if (plcp_mode)
    begin
      case (tref)
        uni_ctrl_pkg::TREF_LOOP:  tx_loop_timing = 1'b1;
        uni_ctrl_pkg::TREF_8K:    use_eight_khz_ref = 1'b1;
        uni_ctrl_pkg::TREF_STUFF: use_stuff_control = 1'b1;
        default:                  use_fixed_stuffing = 1'b1;
      endcase
    end
    else
    begin
      case (tref)
        uni_ctrl_pkg::TREF_LOOP:  tx_loop_timing = 1'b1;
        uni_ctrl_pkg::TREF_STUFF: use_tx_frame_ref = 1'b1;
        default:                  use_tx_input_clock = 1'b1;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Line port
  // ------------------------------------------------------------------
  assign cfg.local_lb    = opmode_ff[uni_ctrl_pkg::OM_LOCAL_LB];
  assign cfg.single_rail = ioctl_ff[uni_ctrl_pkg::IO_SINGLE];
  assign cfg.tx_inv      = ioctl_ff[uni_ctrl_pkg::IO_TX_INV];
  assign cfg.rx_inv      = ioctl_ff[uni_ctrl_pkg::IO_RX_INV];
  assign cfg.loc_dis     = ioctl_ff[uni_ctrl_pkg::IO_LOC_DIS];

  line_port u_line
  (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .cfg             (cfg.line),
    .tx_core_pos     (tx_core_pos),
    .tx_core_neg     (tx_core_neg),
    .rx_core_pos     (rx_core_pos),
    .rx_core_neg     (rx_core_neg),
    .tx_line_clock   (tx_line_clock),
    .rx_line_clock   (rx_line_clock),
    .tx_line_pos_out (tx_line_pos_out),
    .tx_line_neg_out (tx_line_neg_out),
    .rx_line_pos_in  (rx_line_pos_in),
    .rx_line_neg_in  (rx_line_neg_in)
  );
endmodule

// *** pkg/line_cfg_if.sv ***
// Line-side configuration carried from the register bank to the line port
`timescale 1ns/10ps
interface line_cfg_if;
  logic local_lb;
  logic single_rail;
  logic tx_inv;
  logic rx_inv;
  logic loc_dis;
  logic loc_flag;
  modport bank (output local_lb, single_rail, tx_inv, rx_inv, loc_dis,
                input  loc_flag);
  modport line (input  local_lb, single_rail, tx_inv, rx_inv, loc_dis,
                output loc_flag);
endinterface

// *** pkg/uni_ctrl_pkg.sv ***
// Constants and types for the per-channel global control register bank
// What this block does
// - Operating-mode bit 7 loops transmit line outputs into receive inputs.
// - Operating-mode bit 6 enables cell loopback, ATM UNI mode only.
// - Operating-mode bit 5 enables PLCP loopback, PLCP mode only.
// - Writing bit 4 from zero to one resets the whole framer.
// - Bit 3 clear selects PLCP, set selects direct mapping; resets one.
// - Bit 2 clear selects C-bit parity framing, set selects M13.
// - PLCP timing field: receive PLCP, 8 kHz, stuff input, fixed stuffing.
// - Framer timing field: loop, asynchronous, frame reference; resets 11.
// - I/O bit 7 disables clock-loss detector; bit 6 reports lost clock.
// - I/O bit 5 set: reading active status clears its enable bit.
// - I/O bit 4 clear enables B3ZS; software then picks dual rail.
// - I/O bit 3 clear selects dual rail, set selects single rail.
// - I/O bit 2 picks transmit output update edge, rising or falling.
// - I/O bit 1 picks receive input sampling edge, rising or falling.
// - Writing I/O bit 0 from zero to one restarts frame search.
// - Eight interrupt enables, seven block and one-second, all reset to zero, fixed order.
// - Status bits show pending block interrupts, gated by their modes.
// - Status bit 0 is the one-second interrupt, cleared on status read.
// - Test-cell bit 7 clear selects ATM UNI, set selects clear channel.
// - Test-cell bit 6 lets serial input carry overhead in ATM UNI.
package uni_ctrl_pkg;
  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_OPMODE = 8'h00;
  localparam logic [7:0] OFS_IOCTL  = 8'h01;
  localparam logic [7:0] OFS_PARTID = 8'h02;
  localparam logic [7:0] OFS_REVID  = 8'h03;
  localparam logic [7:0] OFS_IRQEN  = 8'h04;
  localparam logic [7:0] OFS_IRQST  = 8'h05;
  localparam logic [7:0] OFS_TCCTL  = 8'h06;
  // Identity values are arbitrary
  localparam logic [7:0] PART_ID_VAL = 8'h5a;
  localparam logic [7:0] REV_ID_VAL  = 8'h3c;
  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int OM_LOCAL_LB = 7;
  localparam int OM_CELL_LB  = 6;
  localparam int OM_PLCP_LB  = 5;
  localparam int OM_RESET    = 4;
  localparam int OM_DIRECT   = 3;
  localparam int OM_M13      = 2;
  localparam int IO_LOC_DIS  = 7;
  localparam int IO_LOC      = 6;
  localparam int IO_EN_CLR   = 5;
  localparam int IO_AMI      = 4;
  localparam int IO_SINGLE   = 3;
  localparam int IO_TX_INV   = 2;
  localparam int IO_RX_INV   = 1;
  localparam int IO_FRAME_SEARCH_RESTART  = 0;
  localparam int TC_CLEAR_CH = 7;
  localparam int TC_OH_IN    = 6;
  localparam int IRQ_RX_PLCP = 6;
  localparam int IRQ_ONE_SEC = 0;
  localparam logic [7:0] OPMODE_RST = 8'h0b;
  localparam logic [7:0] IOCTL_RST  = 8'ha0;
  localparam logic [7:0] IRQEN_RST  = 8'h00;
  localparam logic [7:0] TCCTL_RST  = 8'h00;
  localparam logic [7:0] IOCTL_WMSK = 8'hbf;
  localparam logic [7:0] TCCTL_WMSK = 8'hc0;
  // Status bits 5..2 belong to cell and UTOPIA blocks
  localparam logic [7:0] IRQ_ATM_MSK = 8'h3c;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOC_TIME_NS   = 2000;
  localparam int LOC_CYCLES    = LOC_TIME_NS / CLK_PERIOD_NS;
  localparam int LOC_CW        = $clog2(LOC_CYCLES + 1);
  // ------------------------------------------------------------------
  // Timing reference field
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    TREF_LOOP  = 2'h0,
    TREF_8K    = 2'h1,
    TREF_STUFF = 2'h2,
    TREF_FIXED = 2'h3
  } tref_t;
endpackage

// *** tb/host_model.sv ***
// Host processor model driving the parallel register port
`timescale 1ns/10ps
module host_model
(
  // Clock
  input  wire logic       mclk,
  // Register port
  output logic      [7:0] host_addr = 8'h00,
  output logic      [7:0] host_wdata = 8'h00,
  output logic            host_wr = 1'b0,
  output logic            host_rd = 1'b0,
  input  wire logic [7:0] host_rdata
);
  // Address and data hold until the strobe has been taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge mclk);
    #1;
    host_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge mclk);
    #1;
    host_rd = 1'b0;
    d = host_rdata;
  endtask
endmodule

// *** tb/uni_ctrl_checker.sv ***
// Port-level assertions for the global control register bank
`timescale 1ns/10ps
module uni_ctrl_checker
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       resetn,
  // Register port
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic [7:0] host_rdata,
  // Decoded controls
  input wire logic       framer_soft_reset,
  input wire logic       frame_search_restart,
  input wire logic       cell_loopback_en,
  input wire logic       plcp_loopback_en,
  input wire logic       plcp_enable,
  input wire logic       m13_select,
  input wire logic       b3zs_enable,
  input wire logic       clear_channel_mode,
  input wire logic       tx_overhead_serial_en,
  input wire logic       tx_loop_timing,
  input wire logic       use_eight_khz_ref,
  input wire logic       use_stuff_control,
  input wire logic       use_fixed_stuffing,
  input wire logic       use_tx_frame_ref,
  input wire logic       use_tx_input_clock
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // A write taken while a soft reset is pending is wiped the next cycle
  sequence opm_wr_s;
    host_wr && host_addr == uni_ctrl_pkg::OFS_OPMODE && !framer_soft_reset;
  endsequence
  sequence io_wr_s;
    host_wr && host_addr == uni_ctrl_pkg::OFS_IOCTL && !framer_soft_reset;
  endsequence

  soft_pulse_a : assert property (
    framer_soft_reset |-> $past(host_wr) && $past(host_wdata[4])
      && $past(host_addr) == uni_ctrl_pkg::OFS_OPMODE ##1 !framer_soft_reset)
    else $error("soft reset pulse without its write");
  frame_search_restart_a : assert property (
    frame_search_restart |-> $past(host_wr) && $past(host_wdata[0])
      && $past(host_addr) == uni_ctrl_pkg::OFS_IOCTL ##1 !frame_search_restart)
    else $error("frame_search_restart pulse without its write");
  tref_onehot_a : assert property (
    $onehot({tx_loop_timing, use_eight_khz_ref, use_stuff_control,
             use_fixed_stuffing, use_tx_frame_ref, use_tx_input_clock}))
    else $error("timing source decode not one-hot");
  m13_select_a : assert property (
    opm_wr_s |=> m13_select == $past(host_wdata[uni_ctrl_pkg::OM_M13]))
    else $error("framing format does not follow write");
  b3zs_coding_a : assert property (
    io_wr_s |=> b3zs_enable != $past(host_wdata[uni_ctrl_pkg::IO_AMI]))
    else $error("line coding does not follow write");
  mode_gating_a : assert property (
    cell_loopback_en || plcp_enable || tx_overhead_serial_en
      |-> !clear_channel_mode)
    else $error("cell feature active in clear channel");
  plcp_loop_a : assert property (
    plcp_loopback_en |-> plcp_enable)
    else $error("PLCP loopback outside PLCP mode");
  unmapped_read_a : assert property (
    host_rd && host_addr > uni_ctrl_pkg::OFS_TCCTL |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind uni_ctrl_regs uni_ctrl_checker chk
(
  .mclk(mclk), .resetn(resetn), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
  .host_rdata(host_rdata), .framer_soft_reset(framer_soft_reset),
  .frame_search_restart(frame_search_restart),
  .cell_loopback_en(cell_loopback_en), .plcp_loopback_en(plcp_loopback_en),
  .plcp_enable(plcp_enable), .m13_select(m13_select),
  .b3zs_enable(b3zs_enable), .clear_channel_mode(clear_channel_mode),
  .tx_overhead_serial_en(tx_overhead_serial_en),
  .tx_loop_timing(tx_loop_timing), .use_eight_khz_ref(use_eight_khz_ref),
  .use_stuff_control(use_stuff_control),
  .use_fixed_stuffing(use_fixed_stuffing),
  .use_tx_frame_ref(use_tx_frame_ref),
  .use_tx_input_clock(use_tx_input_clock)
);

// *** tb/uni_ctrl_regs_bench.sv ***
// Self-checking bench for the global control register bank
`timescale 1ns/10ps
module uni_ctrl_regs_bench;
  logic       mclk, resetn, one_second_tick, lclk_run;
  logic [7:1] block_irq_req;
  logic [7:0] host_addr, host_wdata, host_rdata, rv;
  logic       host_wr, host_rd, host_irq, tx_core_pos, tx_core_neg;
  logic       rx_core_pos, rx_core_neg, tx_line_pos_out, tx_line_neg_out;
  logic       rx_line_pos_in, rx_line_neg_in, framer_soft_reset;
  logic       frame_search_restart, cell_loopback_en, plcp_loopback_en;
  logic       plcp_enable, m13_select, b3zs_enable, clear_channel_mode;
  logic       tx_overhead_serial_en, tx_loop_timing, use_eight_khz_ref;
  logic       use_stuff_control, use_fixed_stuffing, use_tx_frame_ref;
  logic       use_tx_input_clock;
  logic [2:0] lc;
  logic [5:0] tref;
  logic [7:0] mode4;
  int         fails, check_count;

  assign tref = {tx_loop_timing, use_eight_khz_ref, use_stuff_control,
                 use_fixed_stuffing, use_tx_frame_ref, use_tx_input_clock};
  assign mode4 = {4'h0, cell_loopback_en, plcp_loopback_en,
                  clear_channel_mode, tx_overhead_serial_en};

  host_model host (.mclk(mclk), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata));

  uni_ctrl_regs dut (.mclk(mclk), .resetn(resetn), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata), .host_irq(host_irq),
    .block_irq_req(block_irq_req), .one_second_tick(one_second_tick),
    .tx_core_pos(tx_core_pos), .tx_core_neg(tx_core_neg),
    .rx_core_pos(rx_core_pos), .rx_core_neg(rx_core_neg),
    .tx_line_clock(lc[2]), .rx_line_clock(lc[2]),
    .tx_line_pos_out(tx_line_pos_out), .tx_line_neg_out(tx_line_neg_out),
    .rx_line_pos_in(rx_line_pos_in), .rx_line_neg_in(rx_line_neg_in),
    .framer_soft_reset(framer_soft_reset),
    .frame_search_restart(frame_search_restart),
    .cell_loopback_en(cell_loopback_en), .plcp_loopback_en(plcp_loopback_en),
    .plcp_enable(plcp_enable), .m13_select(m13_select),
    .b3zs_enable(b3zs_enable), .clear_channel_mode(clear_channel_mode),
    .tx_overhead_serial_en(tx_overhead_serial_en),
    .tx_loop_timing(tx_loop_timing), .use_eight_khz_ref(use_eight_khz_ref),
    .use_stuff_control(use_stuff_control),
    .use_fixed_stuffing(use_fixed_stuffing),
    .use_tx_frame_ref(use_tx_frame_ref),
    .use_tx_input_clock(use_tx_input_clock));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Line clocks at one eighth of mclk; halting them tests clock loss
  always @(posedge mclk)
    if (lclk_run)
      lc <= #1 lc + 3'h1;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk(rv, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic t_reset;
    logic [7:0] exp [8] = '{8'h0b, 8'ha0, uni_ctrl_pkg::PART_ID_VAL,
      uni_ctrl_pkg::REV_ID_VAL, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++)
      rdchk(8'(i), exp[i]);
    host.wr(8'h02, 8'hff);
    rdchk(8'h02, uni_ctrl_pkg::PART_ID_VAL);
    $display("test reset done");
  endtask

  task automatic t_timing;
    for (int f = 0; f < 4; f++)
    begin
      host.wr(8'h00, 8'h08 | 8'(f));
      chk({2'b00, tref}, f == 2 ? 8'h02 : f ? 8'h01 : 8'h20);
      chk({7'h00, plcp_enable}, 8'h00);
      host.wr(8'h00, 8'h04 | 8'(f));
      chk({2'b00, tref}, 8'h20 >> f);
      chk({6'h00, plcp_enable, m13_select}, 8'h03);
    end
    host.wr(8'h00, 8'h0b);
    $display("test timing done");
  endtask

  task automatic t_modes;
    host.wr(8'h00, 8'h60);
    chk(mode4, 8'h0c);
    host.wr(8'h06, 8'hc0);
    chk(mode4, 8'h02);
    host.wr(8'h06, 8'h7f);
    chk(mode4, 8'h0d);
    rdchk(8'h06, 8'h40);
    host.wr(8'h06, 8'h00);
    host.wr(8'h00, 8'h0b);
    $display("test modes done");
  endtask

  task automatic t_irq;
    host.wr(8'h04, 8'hff);
    one_second_tick = 1'b1;
    idle(1);
    one_second_tick = 1'b0;
    chk({7'h00, host_irq}, 8'h01);
    rdchk(8'h05, 8'h01);
    chk({7'h00, host_irq}, 8'h00);
    rdchk(8'h05, 8'h00);
    block_irq_req = 7'h60;
    rdchk(8'h05, 8'h80);
    chk({7'h00, host_irq}, 8'h00);
    rdchk(8'h04, 8'h7e);
    host.wr(8'h01, 8'h80);
    host.wr(8'h04, 8'h80);
    chk({7'h00, host_irq}, 8'h01);
    rdchk(8'h05, 8'h80);
    rdchk(8'h04, 8'h80);
    host.wr(8'h00, 8'h03);
    rdchk(8'h05, 8'hc0);
    host.wr(8'h04, 8'h00);
    chk({7'h00, host_irq}, 8'h00);
    block_irq_req = 7'h00;
    host.wr(8'h00, 8'h0b);
    host.wr(8'h01, 8'ha0);
    $display("test interrupts done");
  endtask

  task automatic t_line;
    tx_core_pos = 1'b1;
    tx_core_neg = 1'b1;
    lclk_run = 1'b1;
    idle(32);
    chk({6'h00, tx_line_pos_out, tx_line_neg_out}, 8'h03);
    chk({6'h00, rx_core_pos, rx_core_neg}, 8'h00);
    host.wr(8'h00, 8'h8b);
    idle(32);
    chk({6'h00, rx_core_pos, rx_core_neg}, 8'h03);
    // Single rail is only chosen with line coding switched off
    host.wr(8'h01, 8'hb8);
    idle(32);
    chk({6'h00, tx_line_pos_out, tx_line_neg_out}, 8'h02);
    host.wr(8'h01, 8'h21);
    chk({7'h00, frame_search_restart}, 8'h01);
    idle(1);
    chk({7'h00, frame_search_restart}, 8'h00);
    lclk_run = 1'b0;
    idle(210);
    rdchk(8'h01, 8'h61);
    lclk_run = 1'b1;
    idle(32);
    rdchk(8'h01, 8'h21);
    // Hand-driven line clock with both edges inverted, loopback still on
    lclk_run = 1'b0;
    host.wr(8'h01, 8'ha6);
    tx_core_pos = 1'b0;
    lc = 3'h4;
    idle(3);
    chk({6'h00, tx_line_pos_out, rx_core_pos}, 8'h03);
    lc = 3'h0;
    idle(3);
    chk({6'h00, tx_line_pos_out, rx_core_pos}, 8'h01);
    lc = 3'h4;
    idle(3);
    chk({6'h00, tx_line_pos_out, rx_core_pos}, 8'h01);
    lc = 3'h0;
    idle(3);
    chk({6'h00, tx_line_pos_out, rx_core_pos}, 8'h00);
    $display("test line done");
  endtask

  task automatic t_soft;
    host.wr(8'h00, 8'h9b);
    chk({7'h00, framer_soft_reset}, 8'h01);
    idle(2);
    rdchk(8'h00, 8'h0b);
    rdchk(8'h01, 8'ha0);
    $display("test soft reset done");
  endtask

  initial
  begin
    repeat (100000) @(posedge mclk);
    fails++;
    conclude;
  end

  initial
  begin
    fails = 0;
    check_count = 0;
    resetn = 1'b0;
    lc = 3'h0;
    lclk_run = 1'b0;
    block_irq_req = 7'h00;
    one_second_tick = 1'b0;
    tx_core_pos = 1'b0;
    tx_core_neg = 1'b0;
    rx_line_pos_in = 1'b0;
    rx_line_neg_in = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    resetn = 1'b1;
    idle(3);
    t_reset;
    t_timing;
    t_modes;
    t_irq;
    t_line;
    t_soft;
    conclude;
  end
endmodule
